// >>> htc_pkg.sv
// Package of field positions, syndrome classes and enumerations for the highest-level trap block
package htc_pkg;

  // ----------------------------------------------------------------
  // Field positions within the configuration word
  // ----------------------------------------------------------------
  localparam int unsigned KEY_ACCESS_TRAP_POS = 16;
  localparam int unsigned ERROR_RECORD_TRAP_POS = 15;
  localparam int unsigned ORDERING_REGION_TRAP_POS = 14;
  localparam int unsigned EVENT_WAIT_TRAP_POS = 13;
  localparam int unsigned INTERRUPT_WAIT_TRAP_POS = 12;
  localparam int unsigned SECURE_TIMER_TRAP_POS = 11;
  localparam int unsigned FIELD_LSB = 11;
  localparam int unsigned FIELD_MSB = 16;

  // ----------------------------------------------------------------
  // Syndrome exception classes
  // ----------------------------------------------------------------
  localparam logic [5:0] EC_UNKNOWN = 6'h00;
  localparam logic [5:0] EC_WAIT = 6'h01;
  localparam logic [5:0] EC_COPROC_32 = 6'h03;
  localparam logic [5:0] EC_SYSREG_64 = 6'h18;

  // Value that fields take on warm reset (architecturally unknown; any value is legal)
  localparam logic [5:0] FIELD_RESET = 6'h00;

  // ----------------------------------------------------------------
  // Exception levels
  // ----------------------------------------------------------------
  localparam logic [1:0] EL0 = 2'h0;
  localparam logic [1:0] EL1 = 2'h1;
  localparam logic [1:0] EL2 = 2'h2;
  localparam logic [1:0] EL3 = 2'h3;

  // Kind of request presented for a trap decision
  typedef enum logic [2:0] {
    HTC_REQ_NONE,
    HTC_REQ_KEY_REG,
    HTC_REQ_ERR_REC,
    HTC_REQ_ERR_REC_EXT,
    HTC_REQ_ORDER_REG,
    HTC_REQ_TIMER_REG,
    HTC_REQ_EVENT_WAIT,
    HTC_REQ_INT_WAIT
  } htc_req_e;

endpackage

// >>> htc_cfg_if.sv
// Interface carrying the effective trap fields from the field store to the decision logic
`timescale 1ns/100ps
`default_nettype none

interface htc_cfg_if;
  logic key_access_trap; // Effective value, zero traps
  logic error_record_trap;
  logic ordering_region_trap;
  logic event_wait_trap;
  logic interrupt_wait_trap;
  logic secure_timer_trap; // Effective value, zero traps
  logic [5:0] stored; // Raw stored field image for readback

  modport store (output key_access_trap, error_record_trap, ordering_region_trap,
                 event_wait_trap, interrupt_wait_trap, secure_timer_trap, stored);
  modport use_cfg (input key_access_trap, error_record_trap, ordering_region_trap,
                   event_wait_trap, interrupt_wait_trap, secure_timer_trap, stored);
endinterface

`default_nettype wire

// >>> htc_field_store.sv
// Storage of the six trap fields with feature gating and effective values
`timescale 1ns/100ps
`default_nettype none

module htc_field_store (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  // Write port
  input wire logic wr_en_in,
  input wire logic [5:0] wr_data_in,
  // Feature presence
  input wire logic feat_pauth_in,
  input wire logic feat_el3_in,
  input wire logic feat_ras_in,
  input wire logic feat_lor_in,
  input wire logic feat_sec_state_in,
  input wire logic feat_realm_in,
  input wire logic sec_el2_en_in,
  // Effective fields out
  htc_cfg_if.store cfg
);

  // ----------------------------------------------------------------
  // Per-bit writable mask
  // ----------------------------------------------------------------
  logic [5:0] field; // Stored field image, bit 0 is the timer trap
  logic [5:0] impl_mask; // One where the governing feature exists
  logic timer_present; // Timer trap exists unless realm-only part

  assign timer_present = !(feat_realm_in && !feat_sec_state_in);
  // Absent features read zero and ignore writes
  assign impl_mask = {feat_pauth_in, feat_ras_in, feat_lor_in, 1'b1, 1'b1,
                      timer_present};

  // Warm reset loads FIELD_RESET (all zero); software must program first
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      field <= htc_pkg::FIELD_RESET;
    end else if (wr_en_in) begin
      field <= wr_data_in & impl_mask;
    end
  end

  assign cfg.stored = field & impl_mask;
  // Key trap: absent feature gives no trap; no EL3 means treated as one
  assign cfg.key_access_trap = !feat_pauth_in || !feat_el3_in || field[5];
  assign cfg.error_record_trap = feat_ras_in && field[4];
  assign cfg.ordering_region_trap = feat_lor_in && field[3];
  assign cfg.event_wait_trap = field[2];
  assign cfg.interrupt_wait_trap = field[1];
  // Secure EL2 enabled forces the no-trap value
  assign cfg.secure_timer_trap = !timer_present || sec_el2_en_in || field[0];

endmodule

`default_nettype wire

// >>> htc_trap_ctrl.sv
// Trap decision logic for the highest-level secure configuration fields
`timescale 1ns/100ps
`default_nettype none

module htc_trap_ctrl (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  // Field write and readback
  input wire logic cfg_wr_en_in,
  input wire logic [5:0] cfg_wr_data_in,
  output logic [5:0] cfg_rd_data_out,
  // Feature presence straps
  input wire logic feat_pauth_in,
  input wire logic feat_el3_in,
  input wire logic feat_ras_in,
  input wire logic feat_ras_ext_in,
  input wire logic feat_lor_in,
  input wire logic feat_timed_wait_in,
  input wire logic feat_sec_state_in,
  input wire logic feat_realm_in,
  input wire logic sec_el2_en_in,
  // Request to decide
  input wire logic req_valid_in,
  input wire logic [2:0] req_kind_in,
  input wire logic [1:0] req_el_in,
  input wire logic req_state32_in,
  input wire logic req_secure_in,
  input wire logic req_timed_in,
  input wire logic req_cond_pass_in,
  input wire logic req_would_block_in,
  input wire logic req_el2_trapped_in,
  input wire logic req_lower_trapped_in,
  input wire logic req_undefined_in,
  // Decision
  output logic dec_valid_out,
  output logic trap_el3_out,
  output logic undef_out,
  output logic [5:0] syndrome_exception_class_out
);

  // ----------------------------------------------------------------
  // Field storage
  // ----------------------------------------------------------------
  htc_cfg_if cfg_bus ();

  htc_field_store u_store (
    .sys_clk_in(sys_clk_in),
    .rstn_in(rstn_in),
    .wr_en_in(cfg_wr_en_in),
    .wr_data_in(cfg_wr_data_in),
    .feat_pauth_in(feat_pauth_in),
    .feat_el3_in(feat_el3_in),
    .feat_ras_in(feat_ras_in),
    .feat_lor_in(feat_lor_in),
    .feat_sec_state_in(feat_sec_state_in),
    .feat_realm_in(feat_realm_in),
    .sec_el2_en_in(sec_el2_en_in),
    .cfg(cfg_bus.store)
  );

  // ----------------------------------------------------------------
  // Request decode
  // ----------------------------------------------------------------
  htc_pkg::htc_req_e kind; // Request kind
  logic below_el3; // Requester is EL0..EL2
  logic el1_or_el2; // Requester is EL1 or EL2
  logic hit_key; // Key register access trapped
  logic hit_err; // Error-record access trapped
  logic hit_lor; // Ordering-region access trapped
  logic hit_timer; // Secure timer access trapped
  logic hit_wait_e; // Event wait trapped
  logic hit_wait_i; // Interrupt wait trapped
  logic wait_ok; // Wait qualifies for trapping
  logic timer_undef; // Timer access undefined at EL0
  logic any_trap; // Some trap fires
  logic [5:0] next_ec; // Syndrome class to report

  assign kind = htc_pkg::htc_req_e'(req_kind_in);
  assign below_el3 = req_el_in != htc_pkg::EL3;
  assign el1_or_el2 = (req_el_in == htc_pkg::EL1) || (req_el_in == htc_pkg::EL2);

  // Key registers trap on a zero field unless EL2 already took it
  assign hit_key = (kind == htc_pkg::HTC_REQ_KEY_REG) && el1_or_el2
                   && !cfg_bus.key_access_trap && !req_el2_trapped_in;

  // Base and extended error-record sets; extended only with the feature
  assign hit_err = el1_or_el2 && cfg_bus.error_record_trap
                   && ((kind == htc_pkg::HTC_REQ_ERR_REC)
                   || (kind == htc_pkg::HTC_REQ_ERR_REC_EXT && feat_ras_ext_in));

  // Ordering-region trap yields to the lower-level trap and to undefined
  assign hit_lor = (kind == htc_pkg::HTC_REQ_ORDER_REG) && el1_or_el2
                   && cfg_bus.ordering_region_trap && !req_undefined_in
                   && !req_el2_trapped_in;

  // Secure timer: Secure EL1 in 64-bit state only; EL3 always passes
  assign hit_timer = (kind == htc_pkg::HTC_REQ_TIMER_REG)
                     && (req_el_in == htc_pkg::EL1) && req_secure_in
                     && !req_state32_in && !cfg_bus.secure_timer_trap;
  assign timer_undef = (kind == htc_pkg::HTC_REQ_TIMER_REG)
                       && (req_el_in == htc_pkg::EL0);

  // Waits: blocking, not caught lower, condition passed in 32-bit state,
  // timed variant only when that feature exists
  assign wait_ok = below_el3 && req_would_block_in && !req_lower_trapped_in
                   && (!req_state32_in || req_cond_pass_in)
                   && (!req_timed_in || feat_timed_wait_in);
  assign hit_wait_e = (kind == htc_pkg::HTC_REQ_EVENT_WAIT) && wait_ok
                      && cfg_bus.event_wait_trap;
  assign hit_wait_i = (kind == htc_pkg::HTC_REQ_INT_WAIT) && wait_ok
                      && cfg_bus.interrupt_wait_trap;

  assign any_trap = hit_key || hit_err || hit_lor || hit_timer || hit_wait_e || hit_wait_i;

  // Syndrome selection; 32-bit error-record accesses use the coprocessor class
  always_comb begin
    next_ec = htc_pkg::EC_UNKNOWN;
    if (hit_wait_e || hit_wait_i) begin
      next_ec = htc_pkg::EC_WAIT;
    end else if (hit_err && req_state32_in) begin
      next_ec = htc_pkg::EC_COPROC_32;
    end else if (any_trap) begin
      next_ec = htc_pkg::EC_SYSREG_64;
    end
  end

  // ----------------------------------------------------------------
  // Registered decision, one cycle after the request
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      dec_valid_out <= 1'b0;
      trap_el3_out <= 1'b0;
      undef_out <= 1'b0;
      syndrome_exception_class_out <= htc_pkg::EC_UNKNOWN;
      cfg_rd_data_out <= htc_pkg::FIELD_RESET;
    end else begin
      dec_valid_out <= req_valid_in;
      trap_el3_out <= req_valid_in && any_trap;
      undef_out <= req_valid_in && timer_undef;
      syndrome_exception_class_out <= req_valid_in ? next_ec : htc_pkg::EC_UNKNOWN;
      cfg_rd_data_out <= cfg_bus.stored;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_wait_class: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (req_valid_in && kind == htc_pkg::HTC_REQ_EVENT_WAIT && wait_ok && cfg_bus.event_wait_trap)
    |=> (trap_el3_out && syndrome_exception_class_out == 6'h01))
    else $error("event wait not trapped with class 0x01");
  a_err_32_class: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (req_valid_in && hit_err && req_state32_in) |=> syndrome_exception_class_out == 6'h03)
    else $error("32-bit error record class wrong");
  a_timer_el2_en: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (req_valid_in && sec_el2_en_in && kind == htc_pkg::HTC_REQ_TIMER_REG) |=> !trap_el3_out)
    else $error("timer trapped with Secure EL2 enabled");
  a_el3_no_trap: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (req_valid_in && req_el_in == htc_pkg::EL3) |=> !trap_el3_out)
    else $error("EL3 request trapped");
  a_cond_fail: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (req_valid_in && req_state32_in && !req_cond_pass_in
     && (kind == htc_pkg::HTC_REQ_EVENT_WAIT || kind == htc_pkg::HTC_REQ_INT_WAIT))
    |=> !trap_el3_out)
    else $error("failed condition wait trapped");
  a_key_el2: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (req_valid_in && kind == htc_pkg::HTC_REQ_KEY_REG && req_el2_trapped_in) |=> !trap_el3_out)
    else $error("key access trapped after EL2 trap");
  a_no_block: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (req_valid_in && !req_would_block_in && kind == htc_pkg::HTC_REQ_INT_WAIT) |=> !trap_el3_out)
    else $error("non-blocking wait trapped");
  a_readback: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (cfg_wr_en_in && !feat_lor_in) |=> ##1 !cfg_rd_data_out[3])
    else $error("absent ordering-region field reads one");

  // Without EL3 the key control must never route anything up
  a_key_no_el3: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (req_valid_in && kind == htc_pkg::HTC_REQ_KEY_REG && !feat_el3_in) |=> !trap_el3_out)
    else $error("key access trapped without EL3");

  // 64-bit error-record access with the field set reports the system-register class
  a_err_64_class: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (req_valid_in && kind == htc_pkg::HTC_REQ_ERR_REC && el1_or_el2 && feat_ras_in
     && cfg_bus.stored[4] && !req_state32_in)
    |=> (trap_el3_out && syndrome_exception_class_out == htc_pkg::EC_SYSREG_64))
    else $error("64-bit error record not trapped with class 0x18");

  // Extended error records exist only with the extension
  a_err_ext_absent: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (req_valid_in && kind == htc_pkg::HTC_REQ_ERR_REC_EXT && !feat_ras_ext_in)
    |=> !trap_el3_out)
    else $error("extended error record trapped without extension");

  // Undefined ordering-region accesses are left to the undefined path
  a_lor_undef: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (req_valid_in && kind == htc_pkg::HTC_REQ_ORDER_REG && req_undefined_in)
    |=> !trap_el3_out)
    else $error("undefined ordering-region access trapped");

  // Timed waits without the feature are never caught here
  a_timed_no_feat: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (req_valid_in && req_timed_in && !feat_timed_wait_in
     && (kind == htc_pkg::HTC_REQ_EVENT_WAIT || kind == htc_pkg::HTC_REQ_INT_WAIT))
    |=> !trap_el3_out)
    else $error("timed wait trapped without feature");

  // Interrupt wait that qualifies reports the wait class
  a_int_wait_class: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (req_valid_in && kind == htc_pkg::HTC_REQ_INT_WAIT && wait_ok
     && cfg_bus.interrupt_wait_trap)
    |=> (trap_el3_out && syndrome_exception_class_out == htc_pkg::EC_WAIT))
    else $error("interrupt wait not trapped with class 0x01");

  // Conditional interrupt wait that fails its condition never traps
  a_int_cond_fail: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (req_valid_in && req_state32_in && !req_cond_pass_in
     && kind == htc_pkg::HTC_REQ_INT_WAIT) |=> !trap_el3_out)
    else $error("failed condition interrupt wait trapped");

  // Secure EL1 64-bit timer access with a clear field goes up
  a_timer_secure: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (req_valid_in && kind == htc_pkg::HTC_REQ_TIMER_REG && req_el_in == htc_pkg::EL1
     && req_secure_in && !req_state32_in && !sec_el2_en_in
     && !(feat_realm_in && !feat_sec_state_in) && !cfg_bus.stored[0])
    |=> (trap_el3_out && syndrome_exception_class_out == htc_pkg::EC_SYSREG_64))
    else $error("secure timer access not trapped");

  // EL0 timer access is undefined, never a trap
  a_timer_el0: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (req_valid_in && kind == htc_pkg::HTC_REQ_TIMER_REG && req_el_in == htc_pkg::EL0)
    |=> (undef_out && !trap_el3_out))
    else $error("EL0 timer access not undefined");

  // Realm part without Secure state keeps the timer bit at zero
  a_realm_timer_rd: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (cfg_wr_en_in && feat_realm_in && !feat_sec_state_in) |=> ##1 !cfg_rd_data_out[0])
    else $error("timer field reads one on realm-only part");

  // No request, no answer
  a_idle_quiet: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (!req_valid_in) |=> (!dec_valid_out && !trap_el3_out
                         && syndrome_exception_class_out == htc_pkg::EC_UNKNOWN))
    else $error("answer without request");

endmodule

`default_nettype wire

// >>> tb_top.sv
// Self-checking testbench for the highest-level trap decision block
`timescale 1ns/100ps
`default_nettype none

`define CHK(g, e, m) begin n_compared++; if ((g) !== (e)) begin n_mismatch++; \
  $display("FAIL %0t %s got %h exp %h", $time, m, g, e); end end

module tb_top;
  // ----------------------------------------------------------------
  // Stimulus and observation signals
  // ----------------------------------------------------------------
  logic sys_clk, rstn, wr_en;
  logic [5:0] wr_data, fld; // Fld is the bench copy of the stored image
  logic [8:0] st; // Straps: pauth el3 ras ras_ext lor timed sec_state realm sec_el2
  logic req_valid, req_state32, req_secure, req_timed, req_cond_pass;
  logic req_would_block, req_el2_trapped, req_lower_trapped, req_undefined;
  logic [2:0] req_kind;
  logic [1:0] req_el;
  logic [5:0] rd, cls;
  logic dec_valid, trap_el3, undef;
  logic [8:0] ex; // Valid, trap, undef, class
  logic [31:0] r;
  integer seed;
  int n_mismatch, n_compared, i, k, e;

  htc_trap_ctrl i_htc_trap_ctrl (.sys_clk_in(sys_clk), .rstn_in(rstn), .cfg_wr_en_in(wr_en),
    .cfg_wr_data_in(wr_data), .cfg_rd_data_out(rd), .feat_pauth_in(st[8]), .feat_el3_in(st[7]),
    .feat_ras_in(st[6]), .feat_ras_ext_in(st[5]), .feat_lor_in(st[4]),
    .feat_timed_wait_in(st[3]), .feat_sec_state_in(st[2]), .feat_realm_in(st[1]),
    .sec_el2_en_in(st[0]), .req_valid_in(req_valid), .req_kind_in(req_kind),
    .req_el_in(req_el), .req_state32_in(req_state32), .req_secure_in(req_secure),
    .req_timed_in(req_timed), .req_cond_pass_in(req_cond_pass),
    .req_would_block_in(req_would_block), .req_el2_trapped_in(req_el2_trapped),
    .req_lower_trapped_in(req_lower_trapped), .req_undefined_in(req_undefined),
    .dec_valid_out(dec_valid), .trap_el3_out(trap_el3), .undef_out(undef),
    .syndrome_exception_class_out(cls));

  // ----------------------------------------------------------------
  // Expected decision for the request now on the inputs
  // ----------------------------------------------------------------
  function automatic logic [8:0] expect_dec();
    logic t, lo, w;
    logic [5:0] c;
    t = 1'b0;
    c = htc_pkg::EC_UNKNOWN;
    lo = (req_el == htc_pkg::EL1) || (req_el == htc_pkg::EL2);
    // Waits trap only when they would block and nothing lower took them
    w = (req_el != htc_pkg::EL3) && req_would_block && !req_lower_trapped &&
        (!req_state32 || req_cond_pass) && (!req_timed || st[3]);
    case (req_kind)
      3'h1: t = lo && st[8] && st[7] && !fld[5] && !req_el2_trapped;
      3'h2: t = lo && fld[4];
      3'h3: t = lo && fld[4] && st[5];
      3'h4: t = lo && fld[3] && !req_undefined && !req_el2_trapped;
      3'h5: t = (req_el == htc_pkg::EL1) && req_secure && !req_state32 && !st[0] &&
                !fld[0];
      3'h6: t = w && fld[2];
      3'h7: t = w && fld[1];
      default: t = 1'b0;
    endcase
    if (t && req_kind > 3'h5) begin
      c = htc_pkg::EC_WAIT;
    end else if (t && req_state32 && (req_kind == 3'h2 || req_kind == 3'h3)) begin
      c = htc_pkg::EC_COPROC_32;
    end else if (t) begin
      c = htc_pkg::EC_SYSREG_64;
    end
    // Without a request every answer bit must stay at its idle value
    return {req_valid, t && req_valid,
            (req_kind == 3'h5) && (req_el == htc_pkg::EL0) && req_valid,
            req_valid ? c : htc_pkg::EC_UNKNOWN};
  endfunction

  // ----------------------------------------------------------------
  // Clock, watchdog and the answer check one cycle after each request
  // ----------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  initial begin
    repeat (20000) @(posedge sys_clk);
    n_mismatch++; // A hang counts against the run
    summarize();
  end

  // Compare at the falling edge, where registered answers have settled
  always @(negedge sys_clk) begin
    if (rstn) begin
      `CHK(dec_valid, ex[8], "valid")
      `CHK(trap_el3, ex[7], "trap")
      `CHK(undef, ex[6], "undef")
      `CHK(cls, ex[5:0], "class")
    end
    ex = rstn ? expect_dec() : 9'h000;
  end

  // ----------------------------------------------------------------
  // Tasks: configure and write fields, present one request, finish
  // ----------------------------------------------------------------
  task automatic cfg(input logic [8:0] s, input logic [5:0] v);
    @(posedge sys_clk);
    st <= s;
    req_valid <= 1'b0;
    wr_en <= 1'b1;
    wr_data <= v;
    @(posedge sys_clk);
    wr_en <= 1'b0;
    // Absent features drop their bit
    // Timer bit is gone only on a realm part without Secure state
    fld = v & {s[8], s[6], s[4], 1'b1, 1'b1, !(s[1] && !s[2])};
    repeat (2) @(posedge sys_clk);
    #1;
    `CHK(rd, fld, "readback")
  endtask

  task automatic apply(input logic [2:0] kd, input logic [1:0] el);
    logic wt;
    wt = kd > 3'h5;
    r = $random(seed);
    @(posedge sys_clk);
    req_valid <= r[9] | r[10];
    req_kind <= kd;
    req_el <= el;
    req_timed <= wt && r[1];
    req_state32 <= (kd == 3'h2 || kd == 3'h3 || kd == 3'h5 || (wt && !r[1])) && r[2];
    req_cond_pass <= r[3] | !wt;
    req_secure <= st[2] && r[4];
    req_would_block <= r[5] | r[11] | !wt;
    req_el2_trapped <= (kd == 3'h1 || kd == 3'h4) && r[6];
    req_lower_trapped <= wt && r[7] && r[12];
    req_undefined <= (kd == 3'h4) && r[8];
  endtask

  task automatic summarize();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    seed = 32'h33ca521f;
    {rstn, wr_en, wr_data, st, req_valid, req_kind, req_el, req_state32} = '0;
    {req_secure, req_timed, req_cond_pass, req_would_block} = '0;
    {req_el2_trapped, req_lower_trapped, req_undefined, fld} = '0;
    n_mismatch = 0;
    n_compared = 0;
    repeat (16) @(posedge sys_clk);
    rstn <= 1'b1;
    // Every kind at every level: fields clear, fields set, Secure EL2 on
    for (i = 0; i < 3; i++) begin
      cfg((i == 2) ? 9'h1fd : 9'h1fc, (i == 1) ? 6'h3f : 6'h00);
      for (k = 0; k < 8; k++) for (e = 0; e < 4; e++) repeat (3) apply(k[2:0], e[1:0]);
    end
    $display("test directed done");
    repeat (60) begin
      r = $random(seed);
      cfg(r[8:0], r[14:9]);
      repeat (20) begin
        r = $random(seed);
        apply(r[2:0], r[4:3]);
      end
    end
    $display("test random done");
    // Reset in mid-run clears every answer
    @(posedge sys_clk);
    req_valid <= 1'b0;
    rstn <= 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
    `CHK({dec_valid, trap_el3, undef, cls}, 9'h000, "reset")
    @(posedge sys_clk);
    rstn <= 1'b1;
    cfg(9'h1fc, 6'h3f);
    repeat (10) apply(3'h6, 2'h0);
    $display("test reset done");
    repeat (3) @(posedge sys_clk);
    summarize();
  end
endmodule

`default_nettype wire
